// ==== dpc_defines.svh ====
// Register offsets, field positions and reset values of the request pacing control
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH

`define DPC_ADDR_W          8
`define DPC_OFS_ENABLE      8'h00
`define DPC_OFS_MUX         8'h04
`define DPC_OFS_ARB         8'h08
`define DPC_OFS_STATUS      8'h0c
`define DPC_OFS_CHCFG       8'h40

`define DPC_ENABLE_RESET    15'h7fff
`define DPC_PAGE_LSB        24
`define DPC_PAGE_LITE_LSB   28
`define DPC_PAGE_RESET      4'h0

`define DPC_MUX_1_BIT       23
`define DPC_MUX_19_20_BIT   24
`define DPC_MUX_21_22_BIT   25
`define DPC_MUX_1_RESET     1'h1
`define DPC_MUX_PAIR_RESET  1'h0

`define DPC_SEC_DIS_BIT     0
`define DPC_SEC_DIS_RESET   1'h0

`define DPC_CFG_SEL_LSB     0
`define DPC_CFG_PACE_RD_BIT 5
`define DPC_CFG_PACE_WR_BIT 6
`define DPC_CFG_WAIT_BIT    7
`define DPC_CFG_RESET       8'h00

`define DPC_STATUS_WR_LSB   16
`define DPC_UNCACHED_TOP    2'h3

`define DPC_LINES           32
`define DPC_RAW_LINES       40
`define DPC_SRC_ALT_1       32
`define DPC_SRC_ALT_19      33
`define DPC_SRC_ALT_21      35
`define DPC_SRC_SEC_24      37

`endif

// ==== dpc_pkg.sv ====
// Types shared by both ends of the request pacing link
package dpc_pkg;

    typedef enum logic [1:0] {
        dpc_rd_idle = 2'b01,
        dpc_rd_busy = 2'b10
    } dpc_rd_state_type;

endpackage

// ==== dpc_link_if.sv ====
// Request lines between peripherals and the pacing control, with take strobes back
`timescale 1ns/1ns
`default_nettype none
interface dpc_link_if;
    logic [31:0] req_main;
    logic        req_alt_1;
    logic [1:0]  req_alt_19_20;
    logic [1:0]  req_alt_21_22;
    logic [2:0]  req_secondary;
    logic [31:0] read_taken;
    logic [31:0] write_taken;

    modport control (
        input  req_main,
        input  req_alt_1,
        input  req_alt_19_20,
        input  req_alt_21_22,
        input  req_secondary,
        output read_taken,
        output write_taken
    );

    modport source (
        output req_main,
        output req_alt_1,
        output req_alt_19_20,
        output req_alt_21_22,
        output req_secondary,
        input  read_taken,
        input  write_taken
    );
endinterface // dpc_link_if
`default_nettype wire

// ==== dpc_control_end.sv ====
// Global enables, page remap, request source mux and per-channel request pacing
//
// What this block does
// - Full engines remap uncached window with page
// - Lite engines use separate lite page field
// - Fifteen channel enable bits, reset to one
// - Software never disables a running channel
// - Channel picks request, paces writes or reads and writes
// - Request line zero is always high
// - Paced read waits request, then all data
// - Peripheral drops request quickly after read
// - Unpaced reads issue only with buffer room
// - APB peripheral readies data before request
// - Writes are always paced by request
// - Peripheral keeps room for in-flight writes
// - Wait-response option allows one outstanding write
// - Thirty-two request inputs with fixed sources
// - Bit 25 selects sources of lines 21-22
// - Bit 24 selects sources of lines 19-20
// - Bit 23 selects line 1 source, resets one
// - Software writes reserved mux bits back unchanged
// - Lines 24-26 merge secondary, with disable
//
// Local design decisions: strobed register access and the register offsets.
`include "dpc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module dpc_control_end
    import dpc_pkg::*;
#(
    parameter int CHANNELS = 15
) (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    dpc_link_if.control                  link,
    input  wire logic [`DPC_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic      [31:0]             reg_rdata,
    output logic      [CHANNELS-1:0]     chan_on,
    input  wire logic [CHANNELS-1:0]     chan_read_want,
    input  wire logic [CHANNELS-1:0]     chan_read_room,
    input  wire logic [CHANNELS-1:0]     chan_read_done,
    output logic      [CHANNELS-1:0]     chan_read_go,
    input  wire logic [CHANNELS-1:0]     chan_write_want,
    input  wire logic [CHANNELS-1:0]     chan_write_resp,
    output logic      [CHANNELS-1:0]     chan_write_go,
    input  wire logic [31:0]             remap_addr_in,
    input  wire logic                    remap_lite,
    output logic      [33:0]             remap_addr_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                        rdata;
        logic [3:0]                         page;
        logic [3:0]                         page_lite;
        logic [CHANNELS-1:0]                chan_on;
        logic                               sel_1;
        logic                               sel_19_20;
        logic                               sel_21_22;
        logic                               sec_dis;
        logic [`DPC_RAW_LINES-1:0]          sync1;
        logic [`DPC_RAW_LINES-1:0]          sync2;
        logic [CHANNELS-1:0][7:0]           cfg;
        dpc_rd_state_type [CHANNELS-1:0]    rd_st;
        logic [CHANNELS-1:0]                wr_out;
        logic [CHANNELS-1:0]                rd_go;
        logic [CHANNELS-1:0]                wr_go;
        logic [31:0]                        read_taken;
        logic [31:0]                        write_taken;
        logic [33:0]                        remap;
    } dpc_ctl_state_type;

    dpc_ctl_state_type st;
    dpc_ctl_state_type next_st;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [`DPC_RAW_LINES-1:0] raw;
        logic [31:0]               line;
        logic [7:0]                cfg_ofs;
        logic [7:0]                cfg_idx;
        logic                      cfg_hit;
        logic [4:0]                sel;
        logic                      req;
        logic                      rd_ok;
        logic                      wr_ok;
        logic [3:0]                pg;
        logic [31:0]               rv;
        logic [CHANNELS-1:0]       busy;

        next_st = st;
        raw = '0;
        line = '0;
        sel = '0;
        req = 1'b0;
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        pg = '0;
        rv = '0;
        busy = '0;
        cfg_ofs = '0;
        cfg_idx = '0;
        cfg_hit = 1'b0;

        // Raw inputs go through two flops; only the second is looked at
        raw = {link.req_secondary, link.req_alt_21_22, link.req_alt_19_20,
               link.req_alt_1, link.req_main};
        next_st.sync1 = raw;
        next_st.sync2 = st.sync1;

        // Fixed map of the 32 lines with the alternate sources folded in
        line = st.sync2[31:0];
        line[0] = 1'b1;
        line[1] = st.sel_1 ? st.sync2[`DPC_SRC_ALT_1] : st.sync2[1];
        line[20:19] = st.sel_19_20 ? st.sync2[`DPC_SRC_ALT_19+:2] : st.sync2[20:19];
        line[22:21] = st.sel_21_22 ? st.sync2[`DPC_SRC_ALT_21+:2] : st.sync2[22:21];
        line[26:24] = st.sync2[26:24] | (st.sync2[`DPC_SRC_SEC_24+:3] & {3{~st.sec_dis}});

        // Channel configuration words sit one per word from the base offset
        cfg_ofs = reg_addr - `DPC_OFS_CHCFG;
        cfg_idx = {2'b00, cfg_ofs[7:2]};
        cfg_hit = (reg_addr >= `DPC_OFS_CHCFG) && (cfg_ofs[1:0] == 2'b00)
                  && (cfg_idx < 8'(CHANNELS));

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (reg_write) begin
            if (reg_addr == `DPC_OFS_ENABLE) begin
                next_st.chan_on = reg_wdata[CHANNELS-1:0];
                next_st.page = reg_wdata[`DPC_PAGE_LSB+:4];
                next_st.page_lite = reg_wdata[`DPC_PAGE_LITE_LSB+:4];
            end else if (reg_addr == `DPC_OFS_MUX) begin
                next_st.sel_1 = reg_wdata[`DPC_MUX_1_BIT];
                next_st.sel_19_20 = reg_wdata[`DPC_MUX_19_20_BIT];
                next_st.sel_21_22 = reg_wdata[`DPC_MUX_21_22_BIT];
            end else if (reg_addr == `DPC_OFS_ARB) begin
                next_st.sec_dis = reg_wdata[`DPC_SEC_DIS_BIT];
            end else if (cfg_hit) begin
                next_st.cfg[cfg_idx[3:0]] = reg_wdata[7:0];
            end
        end

        // ------------------------------------------------------------
        // Per-channel pacing
        // ------------------------------------------------------------
        next_st.read_taken = '0;
        next_st.write_taken = '0;
        for (int ch = 0; ch < CHANNELS; ch++) begin
            sel = st.cfg[ch][`DPC_CFG_SEL_LSB+:5];
            req = line[sel];
            // A disabled channel never starts; stopping a running one is software's hazard
            rd_ok = st.chan_on[ch] && chan_read_want[ch] && chan_read_room[ch]
                    && (st.rd_st[ch] == dpc_rd_idle)
                    && (!st.cfg[ch][`DPC_CFG_PACE_RD_BIT] || req);
            wr_ok = st.chan_on[ch] && chan_write_want[ch] && req
                    && !(st.cfg[ch][`DPC_CFG_WAIT_BIT] && (st.wr_out[ch] || st.wr_go[ch]));
            next_st.rd_go[ch] = rd_ok;
            next_st.wr_go[ch] = wr_ok;
            unique case (st.rd_st[ch])
                dpc_rd_idle: begin
                    if (rd_ok) begin
                        next_st.rd_st[ch] = dpc_rd_busy;
                    end
                end
                dpc_rd_busy: begin
                    if (chan_read_done[ch]) begin
                        next_st.rd_st[ch] = dpc_rd_idle;
                    end
                end
                // Two of the four codes are illegal; fall back to idle rather than hang
                default: begin
                    next_st.rd_st[ch] = dpc_rd_idle;
                end
            endcase
            // A response in the same cycle as a new write leaves the new one counted
            next_st.wr_out[ch] = st.wr_go[ch] | (st.wr_out[ch] & ~chan_write_resp[ch]);
            if (rd_ok && st.cfg[ch][`DPC_CFG_PACE_RD_BIT]) begin
                next_st.read_taken[sel] = 1'b1;
            end
            if (wr_ok) begin
                next_st.write_taken[sel] = 1'b1;
            end
            busy[ch] = (st.rd_st[ch] == dpc_rd_busy);
        end

        // ------------------------------------------------------------
        // Uncached window remap
        // ------------------------------------------------------------
        pg = remap_lite ? st.page_lite : st.page;
        if (remap_addr_in[31:30] == `DPC_UNCACHED_TOP) begin
            next_st.remap = {pg, remap_addr_in[29:0]};
        end else begin
            next_st.remap = {2'b00, remap_addr_in};
        end

        // ------------------------------------------------------------
        // Register reads, data valid the cycle after the strobe
        // ------------------------------------------------------------
        if (reg_addr == `DPC_OFS_ENABLE) begin
            rv[CHANNELS-1:0] = st.chan_on;
            rv[`DPC_PAGE_LSB+:4] = st.page;
            rv[`DPC_PAGE_LITE_LSB+:4] = st.page_lite;
        end else if (reg_addr == `DPC_OFS_MUX) begin
            rv[`DPC_MUX_1_BIT] = st.sel_1;
            rv[`DPC_MUX_19_20_BIT] = st.sel_19_20;
            rv[`DPC_MUX_21_22_BIT] = st.sel_21_22;
        end else if (reg_addr == `DPC_OFS_ARB) begin
            rv[`DPC_SEC_DIS_BIT] = st.sec_dis;
        end else if (reg_addr == `DPC_OFS_STATUS) begin
            rv[CHANNELS-1:0] = busy;
            rv[`DPC_STATUS_WR_LSB+:CHANNELS] = st.wr_out;
        end else if (cfg_hit) begin
            rv[7:0] = st.cfg[cfg_idx[3:0]];
        end
        next_st.rdata = reg_read ? rv : 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st <= '0;
            st.chan_on <= `DPC_ENABLE_RESET;
            st.page <= `DPC_PAGE_RESET;
            st.page_lite <= `DPC_PAGE_RESET;
            st.sel_1 <= `DPC_MUX_1_RESET;
            st.sel_19_20 <= `DPC_MUX_PAIR_RESET;
            st.sel_21_22 <= `DPC_MUX_PAIR_RESET;
            st.sec_dis <= `DPC_SEC_DIS_RESET;
            st.cfg <= {CHANNELS{`DPC_CFG_RESET}};
            for (int c = 0; c < CHANNELS; c++) begin
                st.rd_st[c] <= dpc_rd_idle;
            end
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign chan_on = st.chan_on;
    assign chan_read_go = st.rd_go;
    assign chan_write_go = st.wr_go;
    assign remap_addr_out = st.remap;
    assign link.read_taken = st.read_taken;
    assign link.write_taken = st.write_taken;

endmodule // dpc_control_end
`default_nettype wire

// ==== dpc_source_end.sv ====
// Peripheral side: raises request lines and withdraws them when a paced read is taken
`include "dpc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module dpc_source_end
    import dpc_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    dpc_link_if.source                      link,
    input  wire logic [`DPC_RAW_LINES-1:0]  src_read_ready,
    input  wire logic [`DPC_RAW_LINES-1:0]  src_write_space
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`DPC_RAW_LINES-1:0] req;
        logic [`DPC_RAW_LINES-1:0] holdoff;
    } dpc_src_state_type;

    dpc_src_state_type st;
    dpc_src_state_type next_st;

    // Line number that each source shares on the link
    function automatic logic [4:0] dpc_line_of(input int src);
        if (src < `DPC_LINES) begin
            return 5'(src);
        end else if (src == `DPC_SRC_ALT_1) begin
            return 5'd1;
        end else if (src < `DPC_SRC_ALT_21) begin
            return 5'(src - `DPC_SRC_ALT_19 + 19);
        end else if (src < `DPC_SRC_SEC_24) begin
            return 5'(src - `DPC_SRC_ALT_21 + 21);
        end
        return 5'(src - `DPC_SRC_SEC_24 + 24);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        for (int s = 0; s < `DPC_RAW_LINES; s++) begin
            // Hold the request down after a take until the user's ready falls,
            // so one assertion is never seen twice; set wins over clear
            next_st.holdoff[s] = link.read_taken[dpc_line_of(s)]
                                 | (st.holdoff[s] & src_read_ready[s]);
            // Ready only once all read data is there; space covers in-flight writes
            next_st.req[s] = (src_read_ready[s] & ~next_st.holdoff[s])
                             | src_write_space[s];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.req_main = st.req[31:0];
    assign link.req_alt_1 = st.req[`DPC_SRC_ALT_1];
    assign link.req_alt_19_20 = st.req[`DPC_SRC_ALT_19+:2];
    assign link.req_alt_21_22 = st.req[`DPC_SRC_ALT_21+:2];
    assign link.req_secondary = st.req[`DPC_SRC_SEC_24+:3];

endmodule // dpc_source_end
`default_nettype wire

// ==== dpc_link_properties.sv ====
// Concurrent checks on the request link between the source and control ends
`timescale 1ns/1ns
`default_nettype none
module dpc_link_properties
    import dpc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [31:0] req_main,
    input wire logic        req_alt_1,
    input wire logic [1:0]  req_alt_19_20,
    input wire logic [1:0]  req_alt_21_22,
    input wire logic [2:0]  req_secondary,
    input wire logic [31:0] read_taken,
    input wire logic [31:0] write_taken
);
    default clocking dpc_cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Reset
    // ------------------------------------------------------------
    a_link_reset_quiet: assert property ($rose(resetn) |-> (read_taken == 32'h0 && write_taken == 32'h0))
        else $error("take strobes not clear after reset");
    a_request_reset_low: assert property ($rose(resetn) |-> req_main == 32'h0)
        else $error("request lines not low after reset");

    // ------------------------------------------------------------
    // Pacing: three cycles from a request to its take, through the synchroniser
    // ------------------------------------------------------------
    a_read_needs_request: assert property (read_taken[5] |-> $past(req_main[5], 3))
        else $error("read taken on line 5 without request");
    a_read_single_take: assert property (read_taken[5] |=> !read_taken[5])
        else $error("read take on line 5 longer than one cycle");
    a_source_withdraws: assert property (read_taken[5] |=> !req_main[5])
        else $error("line 5 request not withdrawn after read");
    a_write_needs_request: assert property (write_taken[6] |-> $past(req_main[6], 3))
        else $error("write taken on line 6 without request");

    // ------------------------------------------------------------
    // Shared lines: a take needs one of the line's possible sources
    // ------------------------------------------------------------
    a_line1_source: assert property (read_taken[1] |-> $past(req_main[1], 3) || $past(req_alt_1, 3))
        else $error("line 1 taken without any source");
    a_line19_source: assert property (read_taken[19] |-> $past(req_main[19], 3) || $past(req_alt_19_20[0], 3))
        else $error("line 19 taken without any source");
    a_line21_source: assert property (read_taken[21] |-> $past(req_main[21], 3) || $past(req_alt_21_22[0], 3))
        else $error("line 21 taken without any source");
    a_line24_merge: assert property (read_taken[24] |-> $past(req_main[24], 3) || $past(req_secondary[0], 3))
        else $error("line 24 taken without any source");
endmodule // dpc_link_properties
`default_nettype wire

// ==== test_dma_request_pacing_and_global_control.sv ====
// Self-checking bench joining both ends of the request pacing link
`include "dpc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module test_dma_request_pacing_and_global_control
    import dpc_pkg::*;
;
    logic        sys_clk;
    logic        resetn;
    logic        wr_s;
    logic        rd_s;
    logic        lite;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] ain;
    logic [33:0] aout;
    logic [33:0] d;
    logic [33:0] rd_cnt;
    logic [33:0] wr_cnt;
    logic [14:0] chan_on;
    logic [14:0] r_want;
    logic [14:0] r_room;
    logic [14:0] r_done;
    logic [14:0] r_go;
    logic [14:0] w_want;
    logic [14:0] w_resp;
    logic [14:0] w_go;
    logic [39:0] ready;
    logic [39:0] space;
    int          fails;
    int          checks_done;
    int          cycles;
    logic [31:0] t_in  [3] = '{32'hc000_1234, 32'hc000_1234, 32'h8000_0010};
    logic        t_lite[3] = '{1'h0, 1'h1, 1'h0};
    logic [33:0] t_out [3] = '{34'h2_4000_1234, 34'h0_8000_1234, 34'h0_8000_0010};
    int          m_ch  [4] = '{4, 5, 6, 7};
    int          m_line[4] = '{21, 1, 19, 24};
    int          m_bad [4] = '{21, 32, 19, 37};
    int          m_good[4] = '{35, 1, 33, 24};

    dpc_link_if i_dpc_link_if ();
    dpc_control_end #(.CHANNELS(15)) i_dpc_control_end (
        .sys_clk(sys_clk), .resetn(resetn), .link(i_dpc_link_if),
        .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata),
        .chan_on(chan_on), .chan_read_want(r_want), .chan_read_room(r_room), .chan_read_done(r_done),
        .chan_read_go(r_go), .chan_write_want(w_want), .chan_write_resp(w_resp), .chan_write_go(w_go),
        .remap_addr_in(ain), .remap_lite(lite), .remap_addr_out(aout));
    dpc_source_end i_dpc_source_end (
        .sys_clk(sys_clk), .resetn(resetn), .link(i_dpc_link_if),
        .src_read_ready(ready), .src_write_space(space));
    dpc_link_properties i_dpc_link_properties (
        .sys_clk(sys_clk), .resetn(resetn), .req_main(i_dpc_link_if.req_main),
        .req_alt_1(i_dpc_link_if.req_alt_1), .req_alt_19_20(i_dpc_link_if.req_alt_19_20),
        .req_alt_21_22(i_dpc_link_if.req_alt_21_22), .req_secondary(i_dpc_link_if.req_secondary),
        .read_taken(i_dpc_link_if.read_taken), .write_taken(i_dpc_link_if.write_taken));

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'h1;
        @(posedge sys_clk);
        wr_s <= 1'h0;
    endtask
    // Samples at the edge that closes the answer cycle, so the value is settled
    task automatic rchk(input logic [7:0] a, input logic [33:0] exp, input string nm);
        @(posedge sys_clk);
        addr <= a;
        rd_s <= 1'h1;
        @(posedge sys_clk);
        rd_s <= 1'h0;
        @(posedge sys_clk);
        d[31:0] = rdata;
        chk(nm, exp, d);
    endtask
    task automatic watch(input int n, input int c);
        rd_cnt = 34'h0;
        wr_cnt = 34'h0;
        repeat (n) begin
            @(posedge sys_clk);
            rd_cnt += 34'(r_go[c]);
            wr_cnt += 34'(w_go[c]);
        end
    endtask
    task automatic pulse_done(input int c);
        @(posedge sys_clk);
        r_done[c] <= 1'h1;
        @(posedge sys_clk);
        r_done[c] <= 1'h0;
    endtask
    task automatic pulse_resp(input int c);
        @(posedge sys_clk);
        w_resp[c] <= 1'h1;
        @(posedge sys_clk);
        w_resp[c] <= 1'h0;
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and test sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        {resetn, wr_s, rd_s, lite, addr, wdata, ain, d} = '0;
        {r_want, r_room, r_done, w_want, w_resp, ready, space} = '0;
        fails = 0;
        checks_done = 0;
        cycles = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'h1;
        rchk(`DPC_OFS_ENABLE, 34'h0000_7fff, "enable reset");
        chk("chan_on reset", 34'h7fff, {19'h0, chan_on});
        rchk(`DPC_OFS_MUX, 34'h0080_0000, "mux reset");
        rchk(8'h80, 34'h0, "unmapped read");
        $display("test reset done");
        reg_wr(`DPC_OFS_ENABLE, 32'h5000_2aaa);
        rchk(`DPC_OFS_ENABLE, 34'h5000_2aaa, "enable readback");
        chk("chan_on written", 34'h2aaa, {19'h0, chan_on});
        r_want[2] <= 1'h1;
        r_room[2] <= 1'h1;
        watch(10, 2);
        chk("disabled channel go", 34'h0, rd_cnt);
        reg_wr(`DPC_OFS_ENABLE, 32'h2900_7fff);
        watch(10, 2);
        chk("unpaced go", 34'h1, rd_cnt);
        pulse_done(2);
        r_room[2] <= 1'h0;
        watch(10, 2);
        chk("go without room", 34'h0, rd_cnt);
        r_room[2] <= 1'h1;
        watch(10, 2);
        chk("go with room", 34'h1, rd_cnt);
        pulse_done(2);
        r_want[2] <= 1'h0;
        reg_wr(`DPC_OFS_CHCFG + 8'h04, 32'h20);
        r_want[1] <= 1'h1;
        r_room[1] <= 1'h1;
        watch(10, 1);
        chk("line zero go", 34'h1, rd_cnt);
        pulse_done(1);
        r_want[1] <= 1'h0;
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            ain <= t_in[i];
            lite <= t_lite[i];
            @(posedge sys_clk);
            @(posedge sys_clk);
            chk("remap", t_out[i], aout);
        end
        $display("test enable and remap done");
        reg_wr(`DPC_OFS_CHCFG, 32'h25);
        r_want[0] <= 1'h1;
        r_room[0] <= 1'h1;
        watch(10, 0);
        chk("paced read early", 34'h0, rd_cnt);
        // Data is ready before the request rises
        ready[5] <= 1'h1;
        watch(8, 0);
        chk("paced read go", 34'h1, rd_cnt);
        rchk(`DPC_OFS_STATUS, 34'h1, "read busy");
        ready[5] <= 1'h0;
        @(posedge sys_clk);
        ready[5] <= 1'h1;
        watch(10, 0);
        chk("read while busy", 34'h0, rd_cnt);
        pulse_done(0);
        watch(8, 0);
        chk("read after done", 34'h1, rd_cnt);
        ready[5] <= 1'h0;
        r_want[0] <= 1'h0;
        pulse_done(0);
        $display("test paced read done");
        reg_wr(`DPC_OFS_CHCFG + 8'h0c, 32'h06);
        w_want[3] <= 1'h1;
        watch(10, 3);
        chk("write without request", 34'h0, wr_cnt);
        space[6] <= 1'h1;
        watch(10, 3);
        chk("writes flow", 34'h1, {33'h0, wr_cnt > 34'h1});
        w_want[3] <= 1'h0;
        reg_wr(`DPC_OFS_CHCFG + 8'h0c, 32'h86);
        pulse_resp(3);
        w_want[3] <= 1'h1;
        watch(10, 3);
        chk("one write outstanding", 34'h1, wr_cnt);
        rchk(`DPC_OFS_STATUS, 34'h0008_0000, "write outstanding");
        pulse_resp(3);
        watch(10, 3);
        chk("write after response", 34'h1, wr_cnt);
        w_want[3] <= 1'h0;
        space[6] <= 1'h0;
        $display("test paced write done");
        // Reserved bits go back exactly as read
        rchk(`DPC_OFS_MUX, 34'h0080_0000, "mux before");
        reg_wr(`DPC_OFS_MUX, (d[31:0] & ~32'h0080_0000) | 32'h0300_0000);
        rchk(`DPC_OFS_MUX, 34'h0300_0000, "mux readback");
        reg_wr(`DPC_OFS_ARB, 32'h1);
        for (int i = 0; i < 4; i++) begin
            reg_wr(`DPC_OFS_CHCFG + 8'(4 * m_ch[i]), 32'(m_line[i]) | 32'h20);
            r_want[m_ch[i]] <= 1'h1;
            r_room[m_ch[i]] <= 1'h1;
            ready[m_bad[i]] <= 1'h1;
            watch(10, m_ch[i]);
            chk("unselected source", 34'h0, rd_cnt);
            ready[m_good[i]] <= 1'h1;
            watch(8, m_ch[i]);
            chk("selected source", 34'h1, rd_cnt);
            ready[m_bad[i]] <= 1'h0;
            ready[m_good[i]] <= 1'h0;
            r_want[m_ch[i]] <= 1'h0;
            pulse_done(m_ch[i]);
        end
        $display("test source select done");
        give_verdict();
    end
endmodule // test_dma_request_pacing_and_global_control
`default_nettype wire
